/* rtl/ciex_exec.sv */
// executor for the skip, increment, OR and absolute branch instructions
`timescale 1ns/1ps
`default_nettype none
`include "ciex_defs.svh"
module ciex_exec
	import ciex_pkg::*;
#(
	parameter int PC_W = `CIEX_PC_W
)(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic instr_valid,
	input wire logic [`CIEX_INSTR_W-1:0] instr_word,
	input wire logic [`CIEX_DATA_W-1:0] file_rdata,
	input wire logic [`CIEX_DATA_W-1:0] program_page_latch,
	output logic [`CIEX_FADDR_W-1:0] file_raddr,
	output logic file_we,
	output logic [`CIEX_FADDR_W-1:0] file_waddr,
	output logic [`CIEX_DATA_W-1:0] file_wdata,
	output logic [`CIEX_DATA_W-1:0] accumulator,
	output logic zero_flag,
	output logic [`CIEX_PC_W-1:0] program_counter,
	output logic no_operation_slot,
	output logic illegal_op
);
	// ****************************************
	// elaboration checks
	// ****************************************
	if (PC_W != `CIEX_PC_W) begin : g_pc_w_chk
		$error("ciex_exec: counter width must equal the page plus branch width");
	end

	// ****************************************
	// decode
	// ****************************************
	ciex_core_t st_ff;
	ciex_core_t nxt_st;
	ciex_kind_t kind;
	ciex_alu_if alu_bus ();
	logic [5:0] opc;
	logic dest_reg;

	assign opc = instr_word[`CIEX_OPC_HI:`CIEX_OPC_LO];
	assign dest_reg = instr_word[`CIEX_DEST_BIT];
	assign file_raddr = instr_word[`CIEX_FADDR_W-1:0];

	always_comb begin
		if (instr_word[`CIEX_OPC_HI:`CIEX_BRC_LO] == `CIEX_BRC_CODE) begin
			kind = K_BRANCH;
		end else if (opc == `CIEX_OPC_DECSKIP) begin
			kind = K_DECSKIP;
		end else if (opc == `CIEX_OPC_INCSKIP) begin
			kind = K_INCSKIP;
		end else if (opc == `CIEX_OPC_INCREG) begin
			kind = K_INCREG;
		end else if (opc == `CIEX_OPC_ORREG) begin
			kind = K_ORREG;
		end else if (opc == `CIEX_OPC_ORLIT) begin
			kind = K_ORLIT;
		end else begin
			kind = K_OTHER;
		end
	end

	always_comb begin
		unique case (kind)
			K_DECSKIP: alu_bus.op = ALU_DEC;
			K_INCSKIP, K_INCREG: alu_bus.op = ALU_INC;
			K_ORREG: alu_bus.op = ALU_OR_REG;
			K_ORLIT: alu_bus.op = ALU_OR_LIT;
			default: alu_bus.op = ALU_NONE;
		endcase
	end
	assign alu_bus.acc = st_ff.acc;
	assign alu_bus.fdata = file_rdata;
	assign alu_bus.lit = instr_word[`CIEX_DATA_W-1:0];

	ciex_alu u_alu (
		.bus(alu_bus.alu)
	);

	// ****************************************
	// execute
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		nxt_st.we = 1'b0;
		nxt_st.illegal = 1'b0;
		if (instr_valid) begin
			nxt_st.pc = st_ff.pc + 13'h0001;
			unique case (st_ff.state)
				ST_SKIP: begin
					// squashed slot still walks past its own address
					nxt_st.state = ST_RUN;
				end
				ST_FLUSH: begin
					// prefetched word is stale; counter already holds the target
					nxt_st.pc = st_ff.pc;
					nxt_st.state = ST_RUN;
				end
				ST_RUN: begin
					if (kind == K_BRANCH) begin
						nxt_st.pc = {program_page_latch[`CIEX_PAGE_HI:`CIEX_PAGE_LO],
							instr_word[`CIEX_BR_W-1:0]};
						nxt_st.state = ST_FLUSH;
					end else if (kind == K_OTHER) begin
						nxt_st.illegal = 1'b1;
					end else begin
						if (kind != K_ORLIT && dest_reg) begin
							nxt_st.we = 1'b1;
							nxt_st.waddr = file_raddr;
							nxt_st.wdata = alu_bus.result;
						end else begin
							nxt_st.acc = alu_bus.result;
						end
						if (kind == K_INCREG || kind == K_ORREG || kind == K_ORLIT) begin
							nxt_st.zero = alu_bus.zero_hit;
						end
						if ((kind == K_DECSKIP || kind == K_INCSKIP) && alu_bus.zero_hit) begin
							nxt_st.state = ST_SKIP;
						end
					end
				end
				default: nxt_st.state = ST_RUN;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_ff <= '{state: ST_RUN, acc: `CIEX_RST_ACC, zero: 1'b0, pc: `CIEX_RST_PC,
				we: 1'b0, waddr: '0, wdata: '0, illegal: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign file_we = st_ff.we;
	assign file_waddr = st_ff.waddr;
	assign file_wdata = st_ff.wdata;
	assign accumulator = st_ff.acc;
	assign zero_flag = st_ff.zero;
	assign program_counter = st_ff.pc;
	assign no_operation_slot = (st_ff.state != ST_RUN);
	assign illegal_op = st_ff.illegal;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	logic run_go;
	assign run_go = instr_valid && (st_ff.state == ST_RUN);

	property p_dec_to_acc;
		run_go && kind == K_DECSKIP && !dest_reg
			|=> accumulator == $past(file_rdata) - 8'h01 && zero_flag == $past(zero_flag) && !file_we;
	endproperty
	a_dec_to_acc: assert property (p_dec_to_acc) else $error("decrement to accumulator wrong");

	property p_dec_skip;
		run_go && kind == K_DECSKIP && file_rdata == 8'h01
			##1 instr_valid |=> !file_we && no_operation_slot == 1'b0
			&& program_counter == $past(program_counter, 2) + 13'h0002;
	endproperty
	a_dec_skip: assert property (p_dec_skip) else $error("zero decrement did not squash");

	property p_inc_skip;
		run_go && kind == K_INCSKIP && dest_reg
			|=> file_we && file_wdata == $past(file_rdata) + 8'h01
			&& zero_flag == $past(zero_flag) && no_operation_slot == ($past(file_rdata) == 8'hFF);
	endproperty
	a_inc_skip: assert property (p_inc_skip) else $error("increment skip wrong");

	property p_branch;
		run_go && kind == K_BRANCH
			|=> program_counter == {$past(program_page_latch[4:3]), $past(instr_word[10:0])}
			&& no_operation_slot && zero_flag == $past(zero_flag)
			##1 (!$past(instr_valid) || (!file_we && !illegal_op && !no_operation_slot
			&& program_counter == $past(program_counter)));
	endproperty
	a_branch: assert property (p_branch) else $error("branch target or flush wrong");

	property p_or_lit;
		run_go && kind == K_ORLIT
			|=> accumulator == ($past(accumulator) | $past(instr_word[7:0])) && !file_we;
	endproperty
	a_or_lit: assert property (p_or_lit) else $error("literal OR wrong");

	property p_inc_reg;
		run_go && kind == K_INCREG && dest_reg
			|=> file_we && file_wdata == $past(file_rdata) + 8'h01
			&& file_waddr == $past(instr_word[6:0]) && !no_operation_slot;
	endproperty
	a_inc_reg: assert property (p_inc_reg) else $error("register increment wrong");

	property p_or_reg;
		run_go && kind == K_ORREG && !dest_reg
			|=> accumulator == ($past(accumulator) | $past(file_rdata));
	endproperty
	a_or_reg: assert property (p_or_reg) else $error("register OR wrong");

	property p_zero;
		run_go && (kind == K_INCREG || kind == K_ORREG || kind == K_ORLIT)
			|=> zero_flag == ((($past(kind) != K_ORLIT && $past(dest_reg)) ? file_wdata : accumulator)
			== 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag mismatch");

	c_skip: cover property (run_go && kind == K_INCSKIP && file_rdata == 8'hFF ##1 instr_valid);
	c_branch: cover property (run_go && kind == K_BRANCH ##1 instr_valid);
	c_zero_or: cover property (run_go && kind == K_ORLIT && alu_bus.zero_hit);
endmodule // ciex_exec
`default_nettype wire

/* rtl/ciex_defs.svh */
// constants for the instruction execution subset block
// Function
// - decrement-skip subtracts one; destination bit picks accumulator or register; flags untouched.
// - zero decrement result turns the next instruction into no_operation, two cycles.
// - increment-skip adds one, picks destination, leaves flags, squashes next on zero.
// - branch loads counter low eleven bits from immediate, top two from page latch.
// - or_literal_accumulator ORs accumulator with literal into accumulator, updates zero flag.
// - increment_register adds one, picks destination by bit, updates zero flag.
// - or_accumulator_register ORs accumulator with register, picks destination, updates zero flag.
`ifndef CIEX_DEFS_SVH
`define CIEX_DEFS_SVH

`define CIEX_INSTR_W 14
`define CIEX_DATA_W 8
`define CIEX_PC_W 13
`define CIEX_FADDR_W 7
`define CIEX_BR_W 11
`define CIEX_OPC_HI 13
`define CIEX_OPC_LO 8
`define CIEX_BRC_LO 11
`define CIEX_DEST_BIT 7
`define CIEX_PAGE_HI 4
`define CIEX_PAGE_LO 3
`define CIEX_OPC_DECSKIP 6'h0B
`define CIEX_OPC_INCSKIP 6'h0F
`define CIEX_OPC_INCREG 6'h0A
`define CIEX_OPC_ORREG 6'h04
`define CIEX_OPC_ORLIT 6'h38
`define CIEX_BRC_CODE 3'h5
`define CIEX_RST_PC 13'h0000
`define CIEX_RST_ACC 8'h00

`endif

/* rtl/ciex_pkg.sv */
// types shared by the instruction execution subset block
`include "ciex_defs.svh"
package ciex_pkg;
	typedef enum logic [2:0] {
		ALU_DEC = 3'h0,
		ALU_INC = 3'h1,
		ALU_OR_REG = 3'h2,
		ALU_OR_LIT = 3'h3,
		ALU_NONE = 3'h4
	} ciex_alu_op_t;

	typedef enum logic [2:0] {
		K_DECSKIP = 3'h0,
		K_INCSKIP = 3'h1,
		K_INCREG = 3'h2,
		K_ORREG = 3'h3,
		K_ORLIT = 3'h4,
		K_BRANCH = 3'h5,
		K_OTHER = 3'h6
	} ciex_kind_t;

	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_SKIP = 3'b010,
		ST_FLUSH = 3'b100
	} ciex_state_t;

	typedef struct packed {
		ciex_state_t state;
		logic [`CIEX_DATA_W-1:0] acc;
		logic zero;
		logic [`CIEX_PC_W-1:0] pc;
		logic we;
		logic [`CIEX_FADDR_W-1:0] waddr;
		logic [`CIEX_DATA_W-1:0] wdata;
		logic illegal;
	} ciex_core_t;
endpackage

/* rtl/ciex_alu_if.sv */
// operand and result bundle between the executor and its datapath
`timescale 1ns/1ps
`default_nettype none
`include "ciex_defs.svh"
interface ciex_alu_if;
	import ciex_pkg::*;
	ciex_alu_op_t op;
	logic [`CIEX_DATA_W-1:0] acc;
	logic [`CIEX_DATA_W-1:0] fdata;
	logic [`CIEX_DATA_W-1:0] lit;
	logic [`CIEX_DATA_W-1:0] result;
	logic zero_hit;
	modport core (output op, output acc, output fdata, output lit, input result, input zero_hit);
	modport alu (input op, input acc, input fdata, input lit, output result, output zero_hit);
endinterface
`default_nettype wire

/* rtl/ciex_alu.sv */
// eight-bit datapath for the executor: decrement, increment and inclusive OR
`timescale 1ns/1ps
`default_nettype none
module ciex_alu
	import ciex_pkg::*;
(
	ciex_alu_if.alu bus
);
	always_comb begin
		unique case (bus.op)
			ALU_DEC: bus.result = bus.fdata - 8'h01;
			ALU_INC: bus.result = bus.fdata + 8'h01;
			ALU_OR_REG: bus.result = bus.acc | bus.fdata;
			ALU_OR_LIT: bus.result = bus.acc | bus.lit;
			default: bus.result = bus.acc;
		endcase
	end

	// wraps at eight bits, so 8'hFF plus one is zero too
	assign bus.zero_hit = (bus.result == 8'h00);
endmodule // ciex_alu
`default_nettype wire

/* testbench/core_instr_exec_subset_test.sv */
// self-checking bench for the instruction execution subset
`timescale 1ns/1ps
`default_nettype none
module core_instr_exec_subset_test;
	typedef struct packed {
		logic [7:0] acc;
		logic z;
		logic [12:0] pc;
		logic we;
		logic [6:0] wa;
		logic [7:0] wd;
		logic slot;
		logic ill;
	} ciex_note_t;
	logic core_clk = 0;
	logic srst = 1;
	logic instr_valid = 0;
	logic [13:0] instr_word = 14'h0000;
	logic [7:0] page = 8'h00;
	logic [7:0] mem [128];
	logic [7:0] file_rdata;
	logic [6:0] file_raddr;
	logic file_we;
	logic [6:0] file_waddr;
	logic [7:0] file_wdata;
	logic [7:0] accumulator;
	logic zero_flag;
	logic [12:0] program_counter;
	logic no_operation_slot;
	logic illegal_op;
	ciex_note_t m;
	ciex_note_t e;
	ciex_note_t q [$];
	logic br_pend = 0;
	logic taken = 0;
	logic [13:0] w;
	logic [5:0] opc [5] = '{6'h0B, 6'h0F, 6'h0A, 6'h04, 6'h38};
	int k;
	int fails = 0;
	int n_checks = 0;
	int cycles = 0;
	// register file model: read is combinational, write lands on the edge
	assign file_rdata = mem[file_raddr];
	ciex_exec i_dut (.core_clk(core_clk), .srst(srst), .instr_valid(instr_valid),
		.instr_word(instr_word), .file_rdata(file_rdata), .program_page_latch(page),
		.file_raddr(file_raddr), .file_we(file_we), .file_waddr(file_waddr),
		.file_wdata(file_wdata), .accumulator(accumulator), .zero_flag(zero_flag),
		.program_counter(program_counter), .no_operation_slot(no_operation_slot),
		.illegal_op(illegal_op));
	initial forever #5 core_clk = ~core_clk;
	// ***************************
	// checking
	// ***************************
	task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
		n_checks++;
		if (got !== ex) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge core_clk) begin
		taken <= instr_valid && !srst;
		cycles <= cycles + 1;
		if (cycles > 5000) begin
			fails++;
			wrap_up();
		end
	end
	always @(negedge core_clk) begin
		if (taken && q.size() > 0) begin
			e = q.pop_front();
			chk("acc", 16'(e.acc), 16'(accumulator));
			chk("zero", 16'(e.z), 16'(zero_flag));
			chk("pc", 16'(e.pc), 16'(program_counter));
			chk("we", 16'(e.we), 16'(file_we));
			chk("waddr", 16'(e.wa), 16'(file_waddr));
			chk("wdata", 16'(e.wd), 16'(file_wdata));
			chk("slot", 16'(e.slot), 16'(no_operation_slot));
			chk("illegal", 16'(e.ill), 16'(illegal_op));
		end else if (!srst) begin
			chk("idle we", 16'h0000, 16'(file_we));
		end
	end
	// ***************************
	// stimulus
	// ***************************
	task automatic do_reset();
		srst = 1;
		repeat (3) @(negedge core_clk);
		srst = 0;
		m = '0;
		br_pend = 0;
		chk("rst pc", 16'h0000, 16'(program_counter));
		chk("rst acc", 16'h0000, 16'(accumulator));
		chk("rst flags", 16'h0000, 16'({zero_flag, no_operation_slot, file_we}));
		$display("test reset done");
	endtask
	task automatic issue(input logic [13:0] wd, input int gap);
		logic [7:0] fd;
		logic [7:0] r;
		logic [5:0] op;
		fd = mem[wd[6:0]];
		op = wd[13:8];
		instr_valid = 1;
		instr_word = wd;
		m.we = 0;
		m.ill = 0;
		if (m.slot) begin
			m.slot = 0;
			if (!br_pend) m.pc = m.pc + 13'h0001;
		end else begin
			m.pc = m.pc + 13'h0001;
			br_pend = 0;
			if (wd[13:11] == 3'h5) begin
				m.pc = {page[4:3], wd[10:0]};
				m.slot = 1;
				br_pend = 1;
			end else if (op == 6'h38) begin
				m.acc = m.acc | wd[7:0];
				m.z = (m.acc == 8'h00);
			end else if (op == 6'h0B || op == 6'h0F || op == 6'h0A || op == 6'h04) begin
				r = (op == 6'h0B) ? fd - 8'h01 : (op == 6'h04) ? (m.acc | fd) : fd + 8'h01;
				if (wd[7]) begin
					m.we = 1;
					m.wa = wd[6:0];
					m.wd = r;
				end else m.acc = r;
				if (op == 6'h0A || op == 6'h04) m.z = (r == 8'h00);
				else m.slot = (r == 8'h00);
			end else m.ill = 1;
		end
		q.push_back(m);
		@(posedge core_clk);
		chk("raddr", 16'(wd[6:0]), 16'(file_raddr));
		if (m.we) mem[m.wa] <= m.wd;
		@(negedge core_clk);
		if (gap > 0) begin
			instr_valid = 0;
			repeat (gap) @(negedge core_clk);
		end
	endtask
	initial begin
		void'($urandom(15017));
		// boundary contents so random skips really hit zero
		for (int i = 0; i < 128; i++) begin
			mem[i] = (i % 4 == 0) ? 8'h00 : (i % 4 == 1) ? 8'h01 : 8'hFF;
			if (i % 4 == 3) mem[i] = 8'($urandom);
		end
		mem[16] = 8'h05;
		do_reset();
		issue(14'h0A90, 0);
		issue(14'h0B11, 0);
		issue(14'h0A90, 0);
		issue(14'h0F92, 0);
		issue(14'h3855, 0);
		issue(14'h3800, 0);
		page = 8'h18;
		issue(14'h2FFF, 0);
		issue(14'h0000, 1);
		issue(14'h0000, 1);
		issue(14'h0490, 1);
		$display("test directed done");
		do_reset();
		for (int i = 0; i < 400; i++) begin
			page = 8'($urandom);
			k = $urandom_range(0, 6);
			w = 14'($urandom);
			if (k < 5) w[13:8] = opc[k];
			else if (k == 5) w[13:11] = 3'h5;
			else w[13:8] = 6'h3F;
			issue(w, $urandom_range(0, 2));
		end
		instr_valid = 0;
		repeat (2) @(negedge core_clk);
		chk("left notes", 16'h0000, 16'(q.size()));
		$display("test random done");
		wrap_up();
	end
endmodule // core_instr_exec_subset_test
`default_nettype wire
